// File: hw/dca_consts.vh
`ifndef DCA_CONSTS_VH
`define DCA_CONSTS_VH
// Command codes seen from the management bus engine.
`define DCA_CMD_SNAPSHOT 8'h00
`define DCA_REG_MODE 8'h01
`define DCA_REG_COUNT 8'h02
`define DCA_REG_SUM1 8'h03
`define DCA_REG_SUM2 8'h04
`define DCA_REG_VOLT1 8'h07
`define DCA_REG_VOLT2 8'h08
`define DCA_REG_IDENT 8'h0F
// Control byte field positions.
`define DCA_BIT_POWER 7
`define DCA_BIT_CONT 6
`define DCA_BIT_SINGLE 5
`define DCA_BIT_PARK_EN 4
`define DCA_BIT_PARK_HI 3
`define DCA_BIT_PARK_LO 2
`define DCA_BIT_SLOW 1
`define DCA_BIT_OVF 0
`define DCA_MODE_RESET 8'h00
`define DCA_UNMAPPED_READ 8'hFF
// Byte counts of the readable registers.
`define DCA_LEN_COUNT 4'h3
`define DCA_LEN_SUM 4'h7
`define DCA_LEN_VOLT 4'h2
`define DCA_LEN_BYTE 4'h1
// Sampling: normal rate 4096 sps, slow rate 4 sps, core clock 125 MHz.
`define DCA_CLK_HZ 125000000
`define DCA_FAST_SPS 4096
`define DCA_SLOW_SPS 4
// Single-measure cycles per snapshot: two per channel pass, four when parked.
`define DCA_SINGLE_RR 3'h4
`define DCA_SINGLE_PARK 3'h4
// Full-scale value of the accumulation tally.
`define DCA_TALLY_TOP 24'hFFFFFF
`endif

// File: hw/dca_rate_tick.v
`timescale 1ns/10ps
// Produces a one-cycle sample strobe at the fast or the slow sample rate.
module dca_rate_tick #(
  parameter FAST_DIV = 30517,
  parameter SLOW_DIV = 31250000
) (
  input wire core_clk, // Core clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire run, // Counting enabled; cleared counter while low.
  input wire slow, // Select the slow rate.
  output reg tick // One-cycle sample strobe.
);
  reg [31:0] cnt_r;
  wire [31:0] lim = slow ? SLOW_DIV - 1 : FAST_DIV - 1;

  // Free divider restarted whenever sequencing stops.
  always @(posedge core_clk) begin
    if (!rst_n || !run) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // dca_rate_tick

// File: hw/dca_byte_mux.v
`timescale 1ns/10ps
// Serves one read byte, most significant first, from a 56-bit image.
module dca_byte_mux (
  input wire core_clk, // Core clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire [55:0] image, // Right-aligned register image.
  input wire [3:0] len, // Register length in bytes.
  input wire [3:0] idx, // Byte index within the read, 0 first.
  input wire rd_en, // Read strobe.
  output reg [7:0] rd_data // Registered read byte.
);
  wire [3:0] sel = len - 4'h1 - idx;

  // Picks the byte counted down from the most significant end.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (idx >= len) begin
        rd_data <= 8'h00;
      end else begin
        rd_data <= image[sel[2:0]*8 +: 8];
      end
    end
  end
endmodule // dca_byte_mux

// File: hw/dca_accum_regs.v
`timescale 1ns/10ps
`include "dca_consts.vh"
module dca_accum_regs #(
  parameter FAST_DIV = `DCA_CLK_HZ / `DCA_FAST_SPS,
  parameter SLOW_DIV = `DCA_CLK_HZ / `DCA_SLOW_SPS,
  parameter [23:0] TALLY_TOP = `DCA_TALLY_TOP, // Count at which the tally stops.
  parameter [4:0] PART_ID = 5'h15, // Arbitrary identifier value.
  parameter [2:0] SIL_REV = 3'h1 // Arbitrary revision value.
) (
  input wire core_clk, // Core clock, 125 MHz.
  input wire rst_n, // Synchronous reset, active low.
  input wire [7:0] cmd_code, // Command code from the bus engine.
  input wire send_byte, // Pulse: data-less send-byte with cmd_code.
  input wire wr_en, // Pulse: write byte to cmd_code.
  input wire [7:0] wr_data, // Write byte.
  input wire rd_en, // Pulse: fetch read byte rd_idx of cmd_code.
  input wire [3:0] rd_idx, // Byte index within the read.
  output wire [7:0] rd_data, // Read byte, valid the cycle after rd_en.
  input wire [15:0] cur1, // Channel 1 current sample.
  input wire [15:0] cur2, // Channel 2 current sample.
  input wire [13:0] volt1, // Channel 1 load-side voltage.
  input wire [13:0] volt2, // Channel 2 load-side voltage.
  output wire [7:0] mode_reg, // Control byte as read back.
  output wire busy // Sequencer is accumulating.
);
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states: waiting, accumulating, stopped by overflow.
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_HALT = 3'b100;
  // Full-scale values; sums and tally pin there instead of wrapping.
  localparam [55:0] SUM_MAX = {56{1'b1}};
  localparam [23:0] TALLY_MAX = TALLY_TOP;

  // Saturating add; the flag reports that the result pinned.
  // A carry out of bit 55 marks the sum as pinned at full scale.
  function [56:0] sat_add;
    input [55:0] a;
    input [29:0] b;
    reg [56:0] s;
    begin
      s = {1'b0, a} + {27'h0, b};
      sat_add = s[56] ? {1'b1, SUM_MAX} : s;
    end
  endfunction

  // Steers a tick: parked runs feed only the chosen channel, otherwise they alternate.
  function to_first;
    input parked;
    input park_second;
    input toggle;
    begin
      to_first = parked ? !park_second : !toggle;
    end
  endfunction

  // Control bits 7:1 and the overflow flag, kept apart so bit 0 has its own rules.
  reg [7:0] ctl_r;
  reg ovf_r;
  // Sequencer state, ticks left in a single-measure run and the alternating channel.
  reg [2:0] st_r;
  reg [2:0] left_r;
  reg ch_r;
  // Live sums and tally, and their host-visible snapshots.
  reg [55:0] sum1_r;
  reg [55:0] sum2_r;
  reg [55:0] snap1_r;
  reg [55:0] snap2_r;
  reg [23:0] tally_r;
  reg [23:0] snap_tally_r;
  // Voltage samples latched at the last snapshot.
  reg [13:0] v1_r;
  reg [13:0] v2_r;
  // Candidate sums with their carry, and the terms that feed them.
  reg [56:0] add1;
  reg [56:0] add2;
  reg [29:0] term1;
  reg [29:0] term2;
  // Sample strobe from the rate divider.
  wire tick;
  // Snapshot decode, park selection and the slow-rate request.
  wire snapshot = send_byte && (cmd_code == `DCA_CMD_SNAPSHOT);
  wire park = ctl_r[`DCA_BIT_PARK_EN];
  wire park_ch = (ctl_r[`DCA_BIT_PARK_HI:`DCA_BIT_PARK_LO] == 2'h1);
  wire slow_sel = ctl_r[`DCA_BIT_SLOW];

  // Status outputs: readback with the live flag, and the run indicator.
  assign mode_reg = {ctl_r[7:1], ovf_r};
  assign busy = (st_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // slow rate
  // four samples per second
  // The divider restarts from zero whenever the sequencer leaves the run state.
  // One tick adds one channel, so a parked channel fills twice as fast.
  dca_rate_tick #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(busy),
    .slow(slow_sel),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Terms to add for this tick, current or power per channel.
  always @* begin
    // 30-bit product
    // A 16 by 14 bit product always fits the 30-bit term.
    if (ctl_r[`DCA_BIT_POWER]) begin
      term1 = cur1 * volt1;
      term2 = cur2 * volt2;
    end else begin
      term1 = {14'h0, cur1};
      term2 = {14'h0, cur2};
    end
    add1 = sat_add(sum1_r, term1);
    add2 = sat_add(sum2_r, term2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, overflow flag and sequencer.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      // zero at reset
      // Snapshots and voltages clear too, so early reads return zero.
      ctl_r <= `DCA_MODE_RESET;
      ovf_r <= 1'b0;
      st_r <= ST_IDLE;
      left_r <= 3'h0;
      ch_r <= 1'b0;
      sum1_r <= 56'h0;
      sum2_r <= 56'h0;
      tally_r <= 24'h0;
      snap1_r <= 56'h0;
      snap2_r <= 56'h0;
      snap_tally_r <= 24'h0;
      v1_r <= 14'h0;
      v2_r <= 14'h0;
    end else begin
      // Only the control byte is writable; other codes change nothing.
      // Writes land in any state; keeping them out of continuous runs is the host's part.
      if (wr_en && cmd_code == `DCA_REG_MODE) begin
        ctl_r[7:1] <= wr_data[7:1];
        if (!wr_data[`DCA_BIT_OVF]) begin
          ovf_r <= 1'b0;
        end
      end
      // A snapshot outranks a tick in the same cycle; that tick's sample is dropped.
      if (snapshot) begin
        snap1_r <= sum1_r;
        snap2_r <= sum2_r;
        snap_tally_r <= tally_r;
        v1_r <= volt1;
        v2_r <= volt2;
        // Sums and tally restart together so averages stay consistent.
        sum1_r <= 56'h0;
        sum2_r <= 56'h0;
        tally_r <= 24'h0;
        ch_r <= 1'b0;
        left_r <= park ? `DCA_SINGLE_PARK : `DCA_SINGLE_RR;
        st_r <= ST_RUN;
      end else begin
        case (st_r)
          // Waits for a snapshot; single-measure runs end here.
          ST_IDLE: begin
            st_r <= ST_IDLE;
          end
          ST_RUN: begin
            if (tick) begin
              if (to_first(park, park_ch, ch_r)) begin
                sum1_r <= add1[55:0];
              end else begin
                sum2_r <= add2[55:0];
              end
              if (tally_r != TALLY_MAX) begin
                tally_r <= tally_r + 24'h1;
              end
              // The toggle also runs while parked, where nothing reads it.
              ch_r <= ~ch_r;
              // Single-measure runs count down and drop to idle after the last tick.
              if (ctl_r[`DCA_BIT_SINGLE]) begin
                left_r <= left_r - 3'h1;
                if (left_r == 3'h1) begin
                  st_r <= ST_IDLE;
                end
              end
              // halt on overflow
              // Set after the write clear above, so an event in the same cycle wins.
              if (to_first(park, park_ch, ch_r) ? add1[56] : add2[56]) begin
                ovf_r <= 1'b1;
                st_r <= ST_HALT;
              end else if (tally_r == TALLY_MAX - 24'h1) begin
                // The tally halts on the very step that brings it to its top value.
                ovf_r <= 1'b1;
                st_r <= ST_HALT;
              end
            end
          end
          // Overflow stop; only a snapshot leaves this state.
          ST_HALT: begin
            st_r <= ST_HALT;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read image and length per command code; unknown codes return all ones.
  // Bytes past a register's length read as zero in the byte server.
  reg [55:0] image;
  reg [3:0] len;
  always @* begin
    image = 56'h0;
    len = `DCA_LEN_BYTE;
    case (cmd_code)
      `DCA_REG_MODE: image = {48'h0, mode_reg};
      `DCA_REG_COUNT: begin
        image = {32'h0, snap_tally_r};
        len = `DCA_LEN_COUNT;
      end
      `DCA_REG_SUM1: begin
        image = snap1_r;
        len = `DCA_LEN_SUM;
      end
      `DCA_REG_SUM2: begin
        image = snap2_r;
        len = `DCA_LEN_SUM;
      end
      // Voltage samples sit in bits 15:2 with the two low bits zero.
      `DCA_REG_VOLT1: begin
        image = {40'h0, v1_r, 2'b00};
        len = `DCA_LEN_VOLT;
      end
      `DCA_REG_VOLT2: begin
        image = {40'h0, v2_r, 2'b00};
        len = `DCA_LEN_VOLT;
      end
      // identity byte
      // Identifier and revision are parameters with arbitrary values.
      `DCA_REG_IDENT: image = {48'h0, PART_ID, SIL_REV};
      default: image = {48'h0, `DCA_UNMAPPED_READ};
    endcase
  end

  // most significant first
  // The read byte is registered, so it answers one cycle after the strobe.
  dca_byte_mux u_mux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .image(image),
    .len(len),
    .idx(rd_idx),
    .rd_en(rd_en),
    .rd_data(rd_data)
  );
endmodule // dca_accum_regs

// File: bench/dca_checker_assertions.sv
`timescale 1ns/10ps
// Watches the register block at its ports.
module dca_checker #(
  parameter FAST_DIV = 4,
  parameter [4:0] PART_ID = 5'h15,
  parameter [2:0] SIL_REV = 3'h1
) (
  input wire core_clk, // Clock.
  input wire rst_n, // Reset, active low.
  input wire [7:0] cmd_code, // Code.
  input wire send_byte, // Send-byte.
  input wire wr_en, // Write.
  input wire [7:0] wr_data, // Data.
  input wire rd_en, // Read.
  input wire [3:0] rd_idx, // Index.
  input wire [7:0] rd_data, // Read byte.
  input wire [7:0] mode_reg, // Control byte.
  input wire busy // Accumulating.
);
  // A single-measure run is four ticks plus slack.
  localparam int LIM = 8 * FAST_DIV + 8;
  wire snap = send_byte && cmd_code == 8'h00;
  wire rd0 = rd_en && rd_idx == 4'h0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  chk_ctl_write: assert property (wr_en && cmd_code == 8'h01 |=>
    mode_reg[7:1] == $past(wr_data[7:1])) else $error("control write lost");
  chk_ro_write: assert property (wr_en && cmd_code != 8'h01 && !busy |=>
    mode_reg == $past(mode_reg)) else $error("read-only write took effect");
  chk_snap_busy: assert property (snap |=> busy)
    else $error("snapshot did not start");
  chk_busy_cause: assert property ($rose(busy) |-> $past(snap))
    else $error("busy without snapshot");
  chk_ovf_kept: assert property (snap && !wr_en && mode_reg[0] |=> mode_reg[0])
    else $error("snapshot cleared overflow");
  chk_single_ends: assert property ($rose(busy) && mode_reg[5] && !mode_reg[1]
    |-> ##[1:LIM] !busy) else $error("single measure did not stop");
  chk_read_unmapped: assert property (rd0 && !(cmd_code inside {8'h00, 8'h01,
    8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h0F}) |=> rd_data == 8'hFF)
    else $error("unmapped read not all ones");
  chk_ident_byte: assert property (rd0 && cmd_code == 8'h0F |=>
    rd_data == {PART_ID, SIL_REV}) else $error("identity byte wrong");
  chk_volt_low: assert property (rd_en && rd_idx == 4'h1 &&
    (cmd_code == 8'h07 || cmd_code == 8'h08) |=> rd_data[1:0] == 2'h0)
    else $error("voltage low bits set");
  chk_rd_stands: assert property (!rd_en |=> $stable(rd_data))
    else $error("read byte moved");
  cover property (snap && mode_reg[5]);
  cover property (snap && mode_reg[4]);
  cover property (rd0 && cmd_code == 8'h03);
  cover property ($rose(mode_reg[0]));
endmodule // dca_checker
bind dca_accum_regs dca_checker #(.FAST_DIV(FAST_DIV), .PART_ID(PART_ID),
  .SIL_REV(SIL_REV)) i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .cmd_code(cmd_code), .send_byte(send_byte), .wr_en(wr_en), .wr_data(wr_data),
  .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data), .mode_reg(mode_reg),
  .busy(busy));

// File: bench/dca_host_model.sv
`timescale 1ns/10ps
// Host side: bus engine strobes and the analog samples.
module dca_host_model (
  input wire core_clk, // Clock.
  output reg [7:0] cmd_code, // Code.
  output reg send_byte, // Send-byte.
  output reg wr_en, // Write.
  output reg [7:0] wr_data, // Data.
  output reg rd_en, // Read.
  output reg [3:0] rd_idx, // Index.
  input wire [7:0] rd_data, // Read byte.
  output reg [15:0] cur1, // Current 1.
  output reg [15:0] cur2, // Current 2.
  output reg [13:0] volt1, // Voltage 1.
  output reg [13:0] volt2 // Voltage 2.
);
  // Idle bus and fixed analog levels.
  initial begin
    {cmd_code, send_byte, wr_en, wr_data, rd_en, rd_idx} = 23'h0;
    cur1 = 16'h1234;
    cur2 = 16'hABCD;
    volt1 = 14'h2A5B;
    volt2 = 14'h1FFF;
  end
  task snap;
    begin
      @(posedge core_clk);
      cmd_code <= 8'h00;
      send_byte <= 1'h1;
      @(posedge core_clk);
      send_byte <= 1'h0;
      cmd_code <= 8'hA5;
      #1;
    end
  endtask
  // Writes one byte; the data line is scrambled once released.
  task wr(input [7:0] c, input [7:0] d);
    begin
      @(posedge core_clk);
      cmd_code <= c;
      wr_data <= d;
      wr_en <= 1'h1;
      @(posedge core_clk);
      wr_en <= 1'h0;
      wr_data <= ~d;
    end
  endtask
  task rd(input [7:0] c, input [3:0] n, output [55:0] v);
    integer i;
    begin
      v = 56'h0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk);
        cmd_code <= c;
        rd_idx <= i[3:0];
        rd_en <= 1'h1;
        @(posedge core_clk);
        rd_en <= 1'h0;
        #1 v = {v[47:0], rd_data};
      end
    end
  endtask
endmodule // dca_host_model

// File: bench/test_dca_accum_regs.sv
`timescale 1ns/10ps
// Self-checking bench for the accumulator register block.
module test_dca_accum_regs;
  reg core_clk = 1'h0;
  reg rst_n = 1'h0;
  integer n_errors = 0;
  integer n_compared = 0;
  reg [55:0] v;
  reg [29:0] p;
  wire [7:0] cmd_code, wr_data, rd_data, mode_reg;
  wire [3:0] rd_idx;
  wire send_byte, wr_en, rd_en, busy;
  wire [15:0] cur1, cur2;
  wire [13:0] volt1, volt2;
  always #4 core_clk = ~core_clk;
  dca_host_model i_host (.core_clk(core_clk), .cmd_code(cmd_code), .send_byte(send_byte),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data),
    .cur1(cur1), .cur2(cur2), .volt1(volt1), .volt2(volt2));
  dca_accum_regs #(.FAST_DIV(4), .SLOW_DIV(16), .TALLY_TOP(24'h000006)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n),
    .cmd_code(cmd_code), .send_byte(send_byte), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data), .cur1(cur1), .cur2(cur2),
    .volt1(volt1), .volt2(volt2), .mode_reg(mode_reg), .busy(busy));
  //////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task check(input [55:0] seen, input [55:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
    end
  endtask
  // Reads a register and compares it.
  task rc(input [7:0] c, input [3:0] n, input [55:0] exp);
    begin
      i_host.rd(c, n, v);
      check(v, exp);
    end
  endtask
  // Waits for the sequencer to go idle, bounded.
  task idle;
    integer i;
    begin
      for (i = 0; i < 200 && busy !== 1'h0; i = i + 1) @(posedge core_clk);
      #1 check(busy, 1'h0);
    end
  endtask
  task t_reset;
    begin
      rc(8'h01, 4'h1, 56'h0);
      rc(8'h02, 4'h3, 56'h0);
      rc(8'h03, 4'h7, 56'h0);
      rc(8'h0F, 4'h1, 56'hA9);
      rc(8'h05, 4'h1, 56'hFF);
      $display("t_reset done");
    end
  endtask
  task t_write;
    begin
      i_host.wr(8'h01, 8'h9B);
      rc(8'h01, 4'h1, 56'h9A);
      i_host.wr(8'h02, 8'h55);
      rc(8'h02, 4'h3, 56'h0);
      i_host.wr(8'h01, 8'h00);
      $display("t_write done");
    end
  endtask
  task t_single_rr;
    begin
      i_host.wr(8'h01, 8'h20);
      i_host.snap;
      idle;
      i_host.snap;
      // results are read after this second snapshot latches them.
      rc(8'h02, 4'h3, 56'h4);
      rc(8'h03, 4'h7, 56'h0 + cur1 * 2);
      rc(8'h04, 4'h7, 56'h0 + cur2 * 2);
      rc(8'h07, 4'h2, {volt1, 2'h0});
      rc(8'h08, 4'h2, {volt2, 2'h0});
      $display("t_single_rr done");
    end
  endtask
  task t_park;
    begin
      idle;
      i_host.wr(8'h01, 8'hB4);
      i_host.snap;
      idle;
      i_host.snap;
      p = cur2 * volt2;
      rc(8'h02, 4'h3, 56'h4);
      rc(8'h04, 4'h7, 56'h0 + p * 4);
      $display("t_park done");
    end
  endtask
  // Continuous slow run up to the tally limit, then flag handling.
  task t_ovf;
    begin
      idle;
      // settings first with continuous off, then continuous on.
      // single-measure stays off while continuous runs.
      i_host.wr(8'h01, 8'h02);
      i_host.snap;
      i_host.wr(8'h01, 8'h42);
      i_host.snap;
      repeat (80) @(posedge core_clk);
      #1 check(busy, 1'h1);
      idle;
      rc(8'h01, 4'h1, 56'h43);
      i_host.snap;
      check(busy, 1'h1);
      rc(8'h02, 4'h3, 56'h6);
      rc(8'h03, 4'h7, 56'h0 + cur1 * 3);
      rc(8'h04, 4'h7, 56'h0 + cur2 * 3);
      rc(8'h01, 4'h1, 56'h43);
      idle;
      i_host.wr(8'h01, 8'h43);
      rc(8'h01, 4'h1, 56'h43);
      i_host.wr(8'h01, 8'h42);
      rc(8'h01, 4'h1, 56'h42);
      $display("t_ovf done");
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task final_report;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset;
    t_write;
    t_single_rr;
    t_park;
    t_ovf;
    final_report;
  end
  // Watchdog cuts a hang short.
  initial begin
    #50000;
    n_errors = n_errors + 1;
    final_report;
  end
endmodule // test_dca_accum_regs
